// ==== bench/adc_chip_model.sv ====
// behavioural model of the parallel converter chip behind the port
// assumes the port's strobe struct and a bench-resolved data bus
`timescale 1ns/10ps
module adc_chip_model (
  // clock and reset
  input  logic                       i_clk,
  input  logic                       i_arst_n,
  // strobes and bus from the port
  input  adc_port_pkg::conv_strobe_t i_strobe,
  input  logic [7:0]                 i_data,
  input  logic                       i_data_oe_n,
  // scenario controls: conversion length, never finish
  input  logic [7:0]                 i_delay,
  input  logic                       i_hang,
  // toward the port, and the latched control byte for the bench
  output logic [7:0]                 o_data,
  output logic                       o_done_n,
  output logic [7:0]                 o_ctrl
);
  logic [11:0] raw;
  logic [7:0]  cnt;
  logic [7:0]  last;
  logic        conv;
  logic        wr_sel;
  logic        rd_sel;

  assign wr_sel = !i_strobe.cs_n && !i_strobe.wr_n && !i_data_oe_n;
  assign rd_sel = !i_strobe.cs_n && !i_strobe.rd_n;
  assign raw = {o_ctrl[0], o_ctrl[2:0], 8'ha5};

  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_ctrl <= 8'h00;
      conv <= 1'b0;
      cnt <= 8'h00;
      o_done_n <= 1'b1;
      last <= 8'h00;
    end else begin
      if (wr_sel) begin
        o_ctrl <= i_data;
        conv <= 1'b1;
        cnt <= 8'h00;
        o_done_n <= 1'b1;
      end else if (conv && !i_hang) begin
        cnt <= cnt + 8'h01;
        if (cnt == i_delay) begin
          conv <= 1'b0;
          o_done_n <= 1'b0;
        end
      end
      if (rd_sel) begin
        o_done_n <= 1'b1;
        last <= o_data;
      end
    end
  end

  // released bus shows inverse, top nibble is junk
  always_comb begin
    if (rd_sel) begin
      o_data = i_strobe.hben ? {4'ha, raw[11:8]} : raw[7:0];
    end else begin
      o_data = ~last;
    end
  end
endmodule // adc_chip_model

// ==== bench/testbench.sv ====
// self-checking bench for the converter acquisition port
// assumes the chip model and a 10 MHz clock; design asserts are inline
`timescale 1ns/10ps
`include "adc_port_defs.svh"
module testbench;
  logic        i_clk = 1'b0;
  logic        i_arst_n = 1'b0;
  logic [31:0] i_addr = 32'h0;
  logic [15:0] i_wr_data = 16'h0;
  logic        i_wr = 1'b0;
  logic        i_rd = 1'b0;
  logic [15:0] o_rd_data;
  logic        o_irq;
  adc_port_pkg::conv_strobe_t strobe;
  logic [7:0]  dout;
  logic        oe_n;
  logic [7:0]  chip_dout;
  logic [7:0]  bus;
  logic        done_n;
  logic [7:0]  chip_ctrl;
  logic [7:0]  delay = 8'h1e;
  logic        hang = 1'b0;
  logic        ce = 1'b1;
  int          failures = 0;
  int          total_checks = 0;
  int          cycles = 0;
  logic [7:0]  c;

  assign bus = !oe_n ? dout : chip_dout;

  adc_acquisition_port #(.CONV_TIMEOUT_CYC(200)) adc_acquisition_port_inst (
    .i_clk(i_clk), .i_arst_n(i_arst_n), .i_ce(ce), .i_addr(i_addr),
    .i_wr_data(i_wr_data), .i_wr(i_wr), .i_rd(i_rd),
    .o_rd_data(o_rd_data), .o_irq(o_irq), .o_conv_strobe(strobe),
    .o_conv_data(dout), .o_conv_data_oe_n(oe_n), .i_conv_data(bus),
    .i_conv_done_n(done_n), .i_option_fitted(1'b1));

  adc_chip_model adc_chip_model_inst (
    .i_clk(i_clk), .i_arst_n(i_arst_n), .i_strobe(strobe), .i_data(bus),
    .i_data_oe_n(oe_n), .i_delay(delay), .i_hang(hang),
    .o_data(chip_dout), .o_done_n(done_n), .o_ctrl(chip_ctrl));

  initial begin
    forever #50 i_clk = ~i_clk;
  end

  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 30000) begin
      failures++;
      $display("MISMATCH run_length expected end seen hang");
      stop_test();
    end
  end

  task automatic chk(input string n, input logic [15:0] s,
                     input logic [15:0] e);
    total_checks++;
    if (s !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic wr(input logic [31:0] a, input logic [15:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wr_data <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask

  task automatic rd(input logic [31:0] a, output logic [15:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    @(negedge i_clk);
    d = o_rd_data;
  endtask

  task automatic rdc(input string n, input logic [31:0] a,
                     input logic [15:0] e);
    logic [15:0] d;
    rd(a, d);
    chk(n, d, e);
  endtask

  task automatic wait_idle;
    logic [15:0] s;
    int n;
    s = 16'h0080;
    n = 0;
    while (s[7] !== 1'b0 && n < 400) begin
      rd(`ADDR_STATUS, s);
      n++;
    end
    chk("busy", {8'h00, s[7], 7'h00}, 16'h0000);
  endtask

  function automatic logic [15:0] fmt(input logic [2:0] ch,
                                      input logic bip);
    logic [11:0] r;
    r = {ch[0], ch, 8'ha5};
    fmt = bip ? {{4{r[11]}}, r} : {4'h0, r};
  endfunction

  initial begin
    repeat (4) @(posedge i_clk);
    i_arst_n <= 1'b1;
    repeat (3) @(posedge i_clk);
    rdc("status", `ADDR_STATUS, 16'h0001);
    rdc("unmapped", 32'h2240_000c, 16'h0000);
    rdc("irq_mask", `ADDR_IRQ_MASK, 16'h0000);
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      c = {3'b010, i[2], i[1], i[2:0]};
      wr(`ADDR_CTRL, {8'h00, c});
      rdc("busy_early", `ADDR_STATUS, 16'h0081);
      wait_idle();
      rdc("word", `ADDR_CTRL, fmt(i[2:0], i[1]));
      rdc("high", `ADDR_RES_HI, fmt(i[2:0], i[1]) >> 8);
      chk("chip_ctrl", {8'h00, chip_ctrl}, {8'h00, c});
    end
    $display("test channels done");
    wr(`ADDR_IRQ_STAT, 16'h0003);
    wr(`ADDR_IRQ_MASK, 16'h0001);
    wr(`ADDR_CTRL, 16'h0045);
    wait_idle();
    chk("irq_on", {15'h0, o_irq}, 16'h0001);
    rdc("irq_stat", `ADDR_IRQ_STAT, 16'h0001);
    wr(`ADDR_IRQ_STAT, 16'h0001);
    @(negedge i_clk);
    chk("irq_clr", {15'h0, o_irq}, 16'h0000);
    wr(`ADDR_IRQ_MASK, 16'h0000);
    wr(`ADDR_CTRL, 16'h0045);
    wait_idle();
    chk("irq_masked", {15'h0, o_irq}, 16'h0000);
    rdc("irq_stat_m", `ADDR_IRQ_STAT, 16'h0001);
    $display("test interrupt done");
    wr(`ADDR_CTRL, 16'h0041);
    repeat (10) @(posedge i_clk);
    wr(`ADDR_CTRL, 16'h004e);
    wait_idle();
    rdc("restart", `ADDR_CTRL, fmt(3'h6, 1'b1));
    chk("restart_ctrl", {8'h00, chip_ctrl}, 16'h004e);
    $display("test restart done");
    delay <= 8'h96;
    wr(`ADDR_CTRL, 16'h0047);
    rdc("busy_slow", `ADDR_STATUS, 16'h0081);
    wait_idle();
    rdc("slow", `ADDR_CTRL, fmt(3'h7, 1'b0));
    delay <= 8'h1e;
    $display("test slow done");
    wr(`ADDR_IRQ_STAT, 16'h0003);
    hang <= 1'b1;
    wr(`ADDR_CTRL, 16'h0042);
    wait_idle();
    rdc("tmo_flag", `ADDR_IRQ_STAT, 16'h0002);
    rdc("tmo_keep", `ADDR_CTRL, fmt(3'h7, 1'b0));
    hang <= 1'b0;
    $display("test timeout done");
    wr(`ADDR_IRQ_STAT, 16'h0003);
    wr(`ADDR_CTRL, 16'h0043);
    hang <= 1'b1;
    ce <= 1'b0;
    repeat (300) @(posedge i_clk);
    ce <= 1'b1;
    hang <= 1'b0;
    wait_idle();
    rdc("ce_flags", `ADDR_IRQ_STAT, 16'h0001);
    rdc("ce_word", `ADDR_CTRL, fmt(3'h3, 1'b0));
    $display("test freeze done");
    stop_test();
  end
endmodule // testbench

// ==== design/adc_acquisition_port.sv ====
// control and readout for an optional 8-channel 12-bit converter
// assumes a single 10 MHz clock, a plain register port and a
// parallel converter chip with an active-low end-of-conversion line
//
// Functional notes
// R01 - any write to the control location starts one new acquisition
// R02 - control bits 2:0 pick analog input 0 to 7
// R03 - bit 3 picks bipolar, bit 4 picks the 10 V span
// R04 - software writes bits 7:5 as 0, 1, 0 on every start
// R05 - status bit 0 reads one when the converter option is fitted
// R06 - status bit 7 reads zero once conversion is complete
// R07 - conversion takes about the documented time; timeout guards it
// R08 - control location gives low result byte, next byte gives high
// R09 - a 16-bit read at the control location gives the whole result
// R10 - unipolar results are plain binary with top four bits zero
// R11 - bipolar results sign extend bit 11 into bits 15:12
// R12 - status bit 7 reads one from the start write until completion
`timescale 1ns/10ps
`include "adc_port_defs.svh"
module adc_acquisition_port #(
  parameter int unsigned CONV_TIMEOUT_CYC = `CONV_TIMEOUT_CYC
) (
  // clock, reset, freeze
  input  logic                       i_clk,
  input  logic                       i_arst_n,
  input  logic                       i_ce,
  // register port
  input  logic [`ADDR_W-1:0]         i_addr,
  input  logic [`DATA_W-1:0]         i_wr_data,
  input  logic                       i_wr,
  input  logic                       i_rd,
  output logic [`DATA_W-1:0]         o_rd_data,
  // interrupt
  output logic                       o_irq,
  // converter chip
  output adc_port_pkg::conv_strobe_t o_conv_strobe,
  output logic [7:0]                 o_conv_data,
  output logic                       o_conv_data_oe_n,
  input  logic [7:0]                 i_conv_data,
  input  logic                       i_conv_done_n,
  // option strap
  input  logic                       i_option_fitted
);

  function automatic logic addr_hit(input logic [`ADDR_W-1:0] addr,
                                    input logic [`ADDR_W-1:0] target);
    addr_hit = (addr == target);
  endfunction

  // synchronised pin inputs
  logic                       fitted;
  logic                       done_n;
  logic [7:0]                 pin_data;

  // state
  adc_port_pkg::conv_state_t  state;
  adc_port_pkg::conv_state_t  next_state;
  logic [`CNT_W-1:0]          cnt;
  logic [`CNT_W-1:0]          next_cnt;
  adc_port_pkg::ctrl_t        ctrl;
  logic [7:0]                 lo_byte;
  logic [`DATA_W-1:0]         result;
  logic                       res_bipolar;
  logic [`IRQ_W-1:0]          irq_stat;
  logic [`IRQ_W-1:0]          irq_mask;
  adc_port_pkg::conv_strobe_t next_strobe;
  logic                       next_oe_n;

  // decode and control terms
  logic                       hit_ctrl;
  logic                       hit_res_hi;
  logic                       hit_status;
  logic                       hit_irq_stat;
  logic                       hit_irq_mask;
  logic                       start;
  logic                       busy;
  logic                       in_read;
  logic                       wr_done;
  logic                       rd_done;
  logic                       conv_seen;
  logic                       timed_out;
  logic                       ev_done;
  logic [`IRQ_W-1:0]          irq_set;
  logic [`IRQ_W-1:0]          irq_clr;
  logic [7:0]                 status_byte;
  logic [`DATA_W-1:0]         rd_mux;
  logic [`DATA_W-1:0]         fmt_word;
  logic [`CNT_W-1:0]          tmo_last;

  adc_sync2 #(
    .W (10)
  ) u_sync (
    .i_clk    (i_clk),
    .i_arst_n (i_arst_n),
    .i_ce     (i_ce),
    .i_d      ({i_option_fitted, i_conv_done_n, i_conv_data}),
    .o_q      ({fitted, done_n, pin_data})
  );

  // R10 - formatting of unipolar results
  // R11 - formatting of bipolar results
  adc_result_fmt u_fmt (
    .i_raw     ({pin_data[3:0], lo_byte}),
    .i_bipolar (ctrl.bipolar),
    .o_word    (fmt_word)
  );

  assign hit_ctrl     = addr_hit(i_addr, `ADDR_CTRL);
  assign hit_res_hi   = addr_hit(i_addr, `ADDR_RES_HI);
  assign hit_status   = addr_hit(i_addr, `ADDR_STATUS);
  assign hit_irq_stat = addr_hit(i_addr, `ADDR_IRQ_STAT);
  assign hit_irq_mask = addr_hit(i_addr, `ADDR_IRQ_MASK);

  // R01 - start on control write
  assign start     = i_wr & hit_ctrl;
  // R12 - busy from start to completion
  assign busy      = (state != adc_port_pkg::ST_IDLE);
  assign in_read   = (state == adc_port_pkg::ST_READ_LO) ||
                     (state == adc_port_pkg::ST_READ_HI);
  assign wr_done   = (state == adc_port_pkg::ST_WRITE) &&
                     (cnt == `WR_PULSE_CYC);
  assign rd_done   = in_read && (cnt == `RD_HOLD_CYC);
  // R07 - completion and timeout
  assign tmo_last  = `CNT_W'(CONV_TIMEOUT_CYC - 1);
  assign conv_seen = (state == adc_port_pkg::ST_WAIT) && !done_n &&
                     (cnt >= `DONE_BLANK_CYC);
  assign timed_out = (state == adc_port_pkg::ST_WAIT) && !conv_seen &&
                     (cnt == tmo_last);
  assign ev_done   = (state == adc_port_pkg::ST_READ_HI) && rd_done;

  // sequencer
  always_comb begin
    next_state = state;
    case (state)
      adc_port_pkg::ST_IDLE: begin
        next_state = state;
      end
      adc_port_pkg::ST_WRITE: begin
        if (wr_done) begin
          next_state = adc_port_pkg::ST_WAIT;
        end
      end
      adc_port_pkg::ST_WAIT: begin
        if (conv_seen) begin
          next_state = adc_port_pkg::ST_READ_LO;
        end else if (timed_out) begin
          next_state = adc_port_pkg::ST_IDLE;
        end
      end
      adc_port_pkg::ST_READ_LO: begin
        if (rd_done) begin
          next_state = adc_port_pkg::ST_READ_HI;
        end
      end
      adc_port_pkg::ST_READ_HI: begin
        if (rd_done) begin
          next_state = adc_port_pkg::ST_IDLE;
        end
      end
      default: begin
        next_state = adc_port_pkg::ST_IDLE;
      end
    endcase
    // R01 - a new write restarts from any state
    if (start) begin
      next_state = adc_port_pkg::ST_WRITE;
    end
  end

  assign next_cnt = (start || next_state != state) ? `CNT_RST :
                    cnt + `CNT_W'(1);

  // pin strobes follow the next state so they line up with it
  assign next_strobe.cs_n = (next_state == adc_port_pkg::ST_IDLE) ||
                            (next_state == adc_port_pkg::ST_WAIT);
  assign next_strobe.wr_n = (next_state != adc_port_pkg::ST_WRITE);
  assign next_strobe.rd_n = (next_state != adc_port_pkg::ST_READ_LO) &&
                            (next_state != adc_port_pkg::ST_READ_HI);
  assign next_strobe.hben = (next_state == adc_port_pkg::ST_READ_HI);
  assign next_oe_n        = (next_state != adc_port_pkg::ST_WRITE);

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state            <= adc_port_pkg::ST_IDLE;
      cnt              <= `CNT_RST;
      o_conv_strobe    <= '1;
      o_conv_data_oe_n <= 1'b1;
    end else if (i_ce) begin
      state            <= next_state;
      cnt              <= next_cnt;
      o_conv_strobe    <= next_strobe;
      o_conv_data_oe_n <= next_oe_n;
    end
  end

  // R02 - channel field latched for the chip
  // R03 - polarity and span latched for the chip
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ctrl <= `CTRL_RST;
    end else if (i_ce && start) begin
      ctrl <= i_wr_data[7:0];
    end
  end

  assign o_conv_data = ctrl;

  // R08 - byte capture from the chip
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      lo_byte     <= `BYTE_RST;
      result      <= `RESULT_RST;
      res_bipolar <= 1'b0;
    end else if (i_ce) begin
      if (state == adc_port_pkg::ST_READ_LO && rd_done) begin
        lo_byte <= pin_data;
      end
      if (ev_done) begin
        result      <= fmt_word;
        res_bipolar <= ctrl.bipolar;
      end
    end
  end

  // interrupt flags: set wins over clear
  assign irq_set[`IRQ_DONE_BIT] = ev_done;
  assign irq_set[`IRQ_TMO_BIT]  = timed_out;
  assign irq_clr = (i_wr && hit_irq_stat) ? i_wr_data[`IRQ_W-1:0] :
                   `IRQ_RST;

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      irq_stat <= `IRQ_RST;
      irq_mask <= `IRQ_RST;
    end else if (i_ce) begin
      irq_stat <= (irq_stat & ~irq_clr) | irq_set;
      if (i_wr && hit_irq_mask) begin
        irq_mask <= i_wr_data[`IRQ_W-1:0];
      end
    end
  end

  assign o_irq = |(irq_stat & irq_mask);

  // R05 - fitted flag in bit 0
  // R06 - progress flag in bit 7
  assign status_byte = {busy, `STAT_PAD_W'(0), fitted};

  // R09 - whole word at the control location
  // R08 - high byte alone at the next location
  assign rd_mux = hit_ctrl     ? result :
                  hit_res_hi   ? {8'h00, result[15:8]} :
                  hit_status   ? {8'h00, status_byte} :
                  hit_irq_stat ? {14'h0000, irq_stat} :
                  hit_irq_mask ? {14'h0000, irq_mask} :
                  16'h0000;

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_rd_data <= `RESULT_RST;
    end else if (i_ce) begin
      o_rd_data <= i_rd ? rd_mux : `RESULT_RST;
    end
  end

  // checks
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_arst_n);

  a_start_sets_busy: assert property ( // R12
    (i_ce && start) |=> busy
  ) else $error("busy not set after start write");

  a_start_latches_ctrl: assert property ( // R01
    (i_ce && start) |=> (ctrl == $past(i_wr_data[7:0])) &&
                        (state == adc_port_pkg::ST_WRITE)
  ) else $error("start write did not load control byte");

  a_chan_on_pins: assert property ( // R02
    (state == adc_port_pkg::ST_WRITE) |->
      (o_conv_data[2:0] == ctrl.chan) && !o_conv_data_oe_n &&
      !o_conv_strobe.wr_n
  ) else $error("channel field not driven during write");

  a_range_on_pins: assert property ( // R03
    (state == adc_port_pkg::ST_WRITE) |->
      (o_conv_data[3] == ctrl.bipolar) && (o_conv_data[4] == ctrl.span10)
  ) else $error("range bits not driven during write");

  a_status_fitted: assert property ( // R05
    (i_ce && i_rd && hit_status) |=>
      (o_rd_data[`STAT_FITTED_BIT] == $past(fitted))
  ) else $error("status bit 0 does not show option fitted");

  a_status_busy: assert property ( // R06
    (i_ce && i_rd && hit_status) |=>
      (o_rd_data[`STAT_BUSY_BIT] == $past(busy))
  ) else $error("status bit 7 does not show progress");

  a_wait_bounded: assert property ( // R07
    (state == adc_port_pkg::ST_WAIT) |-> (cnt <= tmo_last)
  ) else $error("wait exceeded conversion timeout");

  a_hi_byte_read: assert property ( // R08
    (i_ce && i_rd && hit_res_hi) |=>
      (o_rd_data == {8'h00, $past(result[15:8])})
  ) else $error("high byte read mismatch");

  a_word_read: assert property ( // R09
    (i_ce && i_rd && hit_ctrl) |=> (o_rd_data == $past(result))
  ) else $error("word read mismatch");

  a_unipolar_zero: assert property ( // R10
    !res_bipolar |-> (result[15:12] == 4'h0)
  ) else $error("unipolar result top bits not zero");

  a_bipolar_sign: assert property ( // R11
    res_bipolar |-> (result[15:12] == {4{result[11]}})
  ) else $error("bipolar result not sign extended");

  a_done_flags: assert property ( // R06
    (i_ce && ev_done && !start) |=> !busy && irq_stat[`IRQ_DONE_BIT]
  ) else $error("completion did not clear busy or set flag");

  c_start: cover property (i_ce && start);
  c_done: cover property (i_ce && ev_done);
  c_timeout: cover property (i_ce && timed_out);
  c_bipolar: cover property (ev_done && ctrl.bipolar);

endmodule // adc_acquisition_port

// ==== design/adc_port_defs.svh ====
// constants for the converter acquisition port: address map, field
// positions, reset values and timing counts
// assumes a 10 MHz core clock and byte addresses on the register port
`ifndef ADC_PORT_DEFS_SVH
`define ADC_PORT_DEFS_SVH

// register port and counter widths
`define ADDR_W          32
`define DATA_W          16
`define CNT_W           20

// address map, byte addresses
`define ADDR_CTRL       32'h10f0_0000
`define ADDR_RES_HI     32'h10f0_0001
`define ADDR_STATUS     32'h2240_0000
`define ADDR_IRQ_STAT   32'h2240_0004
`define ADDR_IRQ_MASK   32'h2240_0008

// status byte fields
`define STAT_FITTED_BIT 0
`define STAT_BUSY_BIT   7
`define STAT_PAD_W      6

// interrupt bits
`define IRQ_W           2
`define IRQ_DONE_BIT    0
`define IRQ_TMO_BIT     1

// reset values
`define CTRL_RST        8'h40
`define IRQ_RST         2'h0
`define RESULT_RST      16'h0000
`define BYTE_RST        8'h00
`define CNT_RST         20'h00000

// timing
`define CLK_PERIOD_NS   100
`define NS_PER_MS       1000000
`define CONV_TIME_MS    12
`define CONV_TIMEOUT_CYC ((`CONV_TIME_MS * `NS_PER_MS) / `CLK_PERIOD_NS)
`define WR_PULSE_CYC    20'h00002
`define RD_HOLD_CYC     20'h00004
`define DONE_BLANK_CYC  20'h00004

`endif

// ==== design/adc_port_pkg.sv ====
// types shared by the converter acquisition port
// assumes adc_port_defs.svh for numeric constants
package adc_port_pkg;

  // control byte as written by software
  typedef struct packed {
    logic [2:0] mode;
    logic       span10;
    logic       bipolar;
    logic [2:0] chan;
  } ctrl_t;

  // strobes toward the converter chip, all active low except hben
  typedef struct packed {
    logic cs_n;
    logic wr_n;
    logic rd_n;
    logic hben;
  } conv_strobe_t;

  // acquisition sequencer
  typedef enum {
    ST_IDLE,
    ST_WRITE,
    ST_WAIT,
    ST_READ_LO,
    ST_READ_HI
  } conv_state_t;

endpackage

// ==== design/adc_result_fmt.sv ====
// formats a 12-bit conversion result into a 16-bit word
// assumes raw data and the polarity flag are stable from flip-flops
`timescale 1ns/10ps
module adc_result_fmt (
  // raw result
  input  logic [11:0] i_raw,
  input  logic        i_bipolar,
  // formatted word
  output logic [15:0] o_word
);

  function automatic logic [15:0] widen(input logic [11:0] raw,
                                        input logic        sgn);
    widen = {{4{sgn & raw[11]}}, raw};
  endfunction

  // R10 - unipolar zero fill
  // R11 - bipolar sign extension
  assign o_word = widen(i_raw, i_bipolar);

endmodule // adc_result_fmt

// ==== design/adc_sync2.sv ====
// two flip-flop synchroniser for pin inputs, one chain per bit
// assumes inputs are asynchronous to i_clk
`timescale 1ns/10ps
module adc_sync2 #(
  parameter int W = 1
) (
  // clock and reset
  input  logic         i_clk,
  input  logic         i_arst_n,
  input  logic         i_ce,
  // data
  input  logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);

  logic [W-1:0] meta;

  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
          meta[g] <= 1'b0;
          o_q[g]  <= 1'b0;
        end else if (i_ce) begin
          meta[g] <= i_d[g];
          o_q[g]  <= meta[g];
        end
      end
    end
  endgenerate

endmodule // adc_sync2
